//--- src/fsp_defs.svh
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register map (byte addresses on the apb bus)
`define FSP_CTRL_OFFS 12'h000
`define FSP_LOCK_OFFS 12'h004

////////////////////////////////////////////////////////////////////////////////
// selfprog_control_reg bit positions
`define FSP_CTRL_IRQ_EN 7
`define FSP_CTRL_BUSY 6
`define FSP_CTRL_EN 0
`define FSP_CMD_LSB 0
`define FSP_CMD_MSB 4

////////////////////////////////////////////////////////////////////////////////
// idle value and legal low-five command patterns
`define FSP_CMD_NONE 5'h00
`define FSP_CMD_LOAD 5'h01
`define FSP_CMD_ERASE 5'h03
`define FSP_CMD_WRITE 5'h05
`define FSP_CMD_LOCK 5'h09
`define FSP_CMD_REEN 5'h11

////////////////////////////////////////////////////////////////////////////////
// arming windows in clock cycles
`define FSP_SPM_WINDOW 3'h4
`define FSP_LPM_WINDOW 3'h3

////////////////////////////////////////////////////////////////////////////////
// pointer values for the armed read sequence
`define FSP_ADDR_FUSE_LO 16'h0000
`define FSP_ADDR_LOCK 16'h0001
`define FSP_ADDR_FUSE_EXT 16'h0002
`define FSP_ADDR_FUSE_HI 16'h0003
`define FSP_EXT_FUSE_MASK 8'h1e
`define FSP_UNUSED_ONES 8'hff
`define FSP_LOCK_PAD 2'h3
`define FSP_BOOT_LOCK_LSB 2
`define FSP_BOOT_LOCK_MSB 5

////////////////////////////////////////////////////////////////////////////////
// reset values and timing
`define FSP_BOOT_LOCK_RESET 4'hf
`define FSP_ERASED_WORD 16'hffff
`define FSP_CLK_PERIOD_NS 10
`define FSP_PROG_TIME_NS 3700000
`define FSP_RWW_PAGES 112

`endif

//--- src/fsp_pkg.sv
package fsp_pkg;

	typedef enum logic [1:0] {fsp_op_erase, fsp_op_write, fsp_op_lock} fsp_op_t;

	typedef enum logic {fsp_idle, fsp_prog} fsp_state_t;

endpackage : fsp_pkg

//--- src/fsp_pbuf_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fsp_pbuf_if
#(
	parameter int WORD_BITS = 6
);
	logic load;
	logic [WORD_BITS-1:0] load_idx;
	logic [15:0] load_data;
	logic clear;
	logic [WORD_BITS-1:0] rd_idx;
	logic [15:0] rd_data;
	logic any_loaded;

	modport ctrl (output load, load_idx, load_data, clear, rd_idx, input rd_data, any_loaded);
	modport store (input load, load_idx, load_data, clear, rd_idx, output rd_data, any_loaded);

endinterface : fsp_pbuf_if

`default_nettype wire

//--- src/fsp_page_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"

module fsp_page_buffer
#(
	parameter int WORD_BITS = 6
)
(
	input wire logic pclk,
	input wire logic por_n,
	fsp_pbuf_if.store buf_if
);

	localparam int DEPTH = 1 << WORD_BITS;

	logic [15:0] mem [DEPTH];
	logic [DEPTH-1:0] valid;

	// data array carries no reset; the valid flags alone define the content
	always_ff @(posedge pclk)
	begin
		if (buf_if.load)
		begin
			mem[buf_if.load_idx] <= buf_if.load_data;
		end
	end

	// clear takes priority; a re-enable write in the same cycle as a load store drops that load
	always_ff @(posedge pclk or negedge por_n)
	begin
		if (!por_n)
		begin
			valid <= '0;
		end
		else if (buf_if.clear)
		begin
			valid <= '0;
		end
		else if (buf_if.load)
		begin
			valid[buf_if.load_idx] <= 1'b1;
		end
	end

	// unloaded slots read as erased cells
	always_ff @(posedge pclk or negedge por_n)
	begin
		if (!por_n)
		begin
			buf_if.rd_data <= `FSP_ERASED_WORD;
		end
		else if (valid[buf_if.rd_idx])
		begin
			buf_if.rd_data <= mem[buf_if.rd_idx];
		end
		else
		begin
			buf_if.rd_data <= `FSP_ERASED_WORD;
		end
	end

	assign buf_if.any_loaded = |valid;

endmodule : fsp_page_buffer

`default_nettype wire

//--- src/fsp_selfprog_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
// Notes on behaviour
// - load command plus store strobe fills buffer slot
// - buffer clears after page write or re-enable
// - buffer clears on every system reset
// - eeprom write during loading discards buffer
// - page write programs buffer into selected page
// - rww target keeps core running; no_rww_section halts
// - ready interrupt asserted while enable reads clear
// - rww reads blocked, busy flag set
// - lock set command programs boot locks only
// - zero data bits 5..2 program boot locks
// - pointer ignored during lock bit setting
// - lock programming never halts nor blocks fetches
// - eeprom write blocks commands and fuse reads
// - armed load-program returns lock byte
// - lock-read arm clears on read or timeout
// - unarmed load-program is ordinary memory read
// - pointer selects fuse low, high, extended
// - programmed bits read zero, unprogrammed one
// - system reset never aborts running flash write; power-on reset does
// - enable arms store four cycles, held while busy
// - only five low-bit patterns take effect
// - page load clears section busy flag

module fsp_selfprog_ctrl
#(
	parameter int WORD_BITS = 6,
	parameter int PAGE_BITS = 7,
	parameter int RWW_PAGES = `FSP_RWW_PAGES,
	parameter int PROG_CYCLES = (`FSP_PROG_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic spm_strobe,
	input wire logic lpm_strobe,
	input wire logic [15:0] zptr,
	input wire logic [15:0] data_word_pair,
	input wire logic eeprom_write_active,
	input wire logic [7:0] fuse_low_byte,
	input wire logic [7:0] fuse_high_byte,
	input wire logic [7:0] extended_fuse_byte,
	input wire logic [1:0] general_locks,
	output logic [7:0] lpm_data,
	output logic lpm_special,
	output logic spm_ready_irq,
	output logic rww_read_block,
	output logic core_halt,
	output logic prog_active,
	output fsp_pkg::fsp_op_t prog_op,
	output logic [PAGE_BITS-1:0] prog_page,
	output logic [3:0] boot_locks,
	input wire logic [WORD_BITS-1:0] prog_buf_idx,
	output logic [15:0] prog_buf_data
);
	import fsp_pkg::*;

	if (WORD_BITS < 1 || PAGE_BITS < 1 || WORD_BITS + PAGE_BITS + 1 > 16)
	begin : g_bad_geometry
		$error("page geometry does not fit a 16-bit pointer");
	end
	if (PROG_CYCLES < 1 || RWW_PAGES > (1 << PAGE_BITS))
	begin : g_bad_timing
		$error("programming time or rww page count out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// declarations

	fsp_pbuf_if #(.WORD_BITS(WORD_BITS)) pbuf ();

	logic [4:0] arm_cmd;
	logic [2:0] arm_age;
	logic irq_en;
	logic section_busy_flag;
	logic clear_pending;
	fsp_state_t state;
	logic [31:0] prog_cnt;
	logic [3:0] lock_new;
	logic running;
	logic spm_enable;
	logic ctrl_wr;
	logic ctrl_wr_ok;
	logic spm_go;
	logic lpm_go;
	logic eng_start;
	logic eng_done;
	logic start_rww;
	logic [PAGE_BITS-1:0] z_page;
	logic [7:0] armed_byte;
	logic [31:0] rd_word;
	logic rd_hit;

	function automatic logic legal_cmd(input logic [4:0] c);
		legal_cmd = (c == `FSP_CMD_LOAD) || (c == `FSP_CMD_ERASE) || (c == `FSP_CMD_WRITE) ||
			(c == `FSP_CMD_LOCK) || (c == `FSP_CMD_REEN);
	endfunction : legal_cmd

	////////////////////////////////////////////////////////////////////////////
	// request decode

	assign running = (state == fsp_prog);
	assign spm_enable = arm_cmd[`FSP_CTRL_EN] | running;
	assign ctrl_wr = psel && penable && pwrite && (paddr == `FSP_CTRL_OFFS) && pstrb[0];
	// command bits ignored while eeprom busy, flash busy, or pattern illegal
	assign ctrl_wr_ok = ctrl_wr && !eeprom_write_active && !running &&
		legal_cmd(pwdata[`FSP_CMD_MSB:`FSP_CMD_LSB]);
	assign spm_go = spm_strobe && (arm_cmd != `FSP_CMD_NONE) && !eeprom_write_active && !running;
	assign lpm_go = lpm_strobe && (arm_cmd == `FSP_CMD_LOCK) && (arm_age < `FSP_LPM_WINDOW) &&
		!eeprom_write_active;
	assign eng_start = spm_go && ((arm_cmd == `FSP_CMD_WRITE) || (arm_cmd == `FSP_CMD_ERASE) ||
		(arm_cmd == `FSP_CMD_LOCK));
	assign eng_done = running && (prog_cnt == 32'h0000_0000);
	assign z_page = zptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
	assign start_rww = (32'(z_page) < 32'(RWW_PAGES)) && (arm_cmd != `FSP_CMD_LOCK);

	////////////////////////////////////////////////////////////////////////////
	// arming window and interrupt enable

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			arm_cmd <= `FSP_CMD_NONE;
			arm_age <= 3'h0;
		end
		else if (ctrl_wr_ok)
		begin
			arm_cmd <= pwdata[`FSP_CMD_MSB:`FSP_CMD_LSB];
			arm_age <= 3'h0;
		end
		else if (arm_cmd != `FSP_CMD_NONE)
		begin
			// lock-read arm stays for a store until the longer window ends
			if (spm_go || lpm_go || (arm_age == `FSP_SPM_WINDOW - 3'h1))
			begin
				arm_cmd <= `FSP_CMD_NONE;
			end
			else
			begin
				arm_age <= arm_age + 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_en <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			irq_en <= pwdata[`FSP_CTRL_IRQ_EN];
		end
	end

	assign spm_ready_irq = irq_en && !spm_enable;

	////////////////////////////////////////////////////////////////////////////
	// section busy flag and read blocking

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			section_busy_flag <= 1'b0;
		end
		else if (eng_start && start_rww)
		begin
			section_busy_flag <= 1'b1;
		end
		else if (spm_go && ((arm_cmd == `FSP_CMD_LOAD) || (arm_cmd == `FSP_CMD_REEN)))
		begin
			section_busy_flag <= 1'b0;
		end
	end

	// lock programming leaves every section readable
	assign rww_read_block = section_busy_flag ||
		(running && (prog_op != fsp_op_lock) && (32'(prog_page) < 32'(RWW_PAGES)));
	assign core_halt = running && (prog_op != fsp_op_lock) && (32'(prog_page) >= 32'(RWW_PAGES));

	////////////////////////////////////////////////////////////////////////////
	// programming engine, on power-on reset so a system reset cannot abort it

	always_ff @(posedge pclk or negedge por_n)
	begin
		if (!por_n)
		begin
			state <= fsp_idle;
			prog_cnt <= 32'h0000_0000;
			prog_op <= fsp_op_write;
			prog_page <= '0;
			lock_new <= `FSP_BOOT_LOCK_RESET;
			boot_locks <= `FSP_BOOT_LOCK_RESET;
		end
		else
		begin
			case (state)
				fsp_idle:
				begin
					if (eng_start)
					begin
						state <= fsp_prog;
						prog_cnt <= 32'(PROG_CYCLES - 1);
						prog_page <= z_page;
						lock_new <= data_word_pair[`FSP_BOOT_LOCK_MSB:`FSP_BOOT_LOCK_LSB];
						if (arm_cmd == `FSP_CMD_WRITE)
						begin
							prog_op <= fsp_op_write;
						end
						else if (arm_cmd == `FSP_CMD_ERASE)
						begin
							prog_op <= fsp_op_erase;
						end
						else
						begin
							prog_op <= fsp_op_lock;
						end
					end
				end
				fsp_prog:
				begin
					if (prog_cnt == 32'h0000_0000)
					begin
						state <= fsp_idle;
						if (prog_op == fsp_op_lock)
						begin
							// cells only ever move to programmed (zero)
							boot_locks <= boot_locks & lock_new;
						end
					end
					else
					begin
						prog_cnt <= prog_cnt - 32'h0000_0001;
					end
				end
				default:
				begin
					state <= fsp_idle;
				end
			endcase
		end
	end

	assign prog_active = running;

	////////////////////////////////////////////////////////////////////////////
	// temporary page buffer

	// after a system reset the wipe waits until any running write is done
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clear_pending <= 1'b1;
		end
		else if (!running)
		begin
			clear_pending <= 1'b0;
		end
	end

	assign pbuf.load = spm_go && (arm_cmd == `FSP_CMD_LOAD);
	assign pbuf.load_idx = zptr[WORD_BITS:1];
	assign pbuf.load_data = data_word_pair;
	assign pbuf.clear = (clear_pending && !running) ||
		(eng_done && (prog_op == fsp_op_write)) ||
		(ctrl_wr_ok && (pwdata[`FSP_CMD_MSB:`FSP_CMD_LSB] == `FSP_CMD_REEN)) ||
		(eeprom_write_active && pbuf.any_loaded && !running);
	assign pbuf.rd_idx = prog_buf_idx;
	assign prog_buf_data = pbuf.rd_data;

	fsp_page_buffer #(.WORD_BITS(WORD_BITS)) u_buffer
	(
		.pclk(pclk),
		.por_n(por_n),
		.buf_if(pbuf.store)
	);

	////////////////////////////////////////////////////////////////////////////
	// armed load-program read of fuse and lock bytes

	always_comb
	begin
		armed_byte = `FSP_UNUSED_ONES;
		if (zptr == `FSP_ADDR_LOCK)
		begin
			armed_byte = {`FSP_LOCK_PAD, boot_locks, general_locks};
		end
		else if (zptr == `FSP_ADDR_FUSE_LO)
		begin
			armed_byte = fuse_low_byte;
		end
		else if (zptr == `FSP_ADDR_FUSE_HI)
		begin
			armed_byte = fuse_high_byte;
		end
		else if (zptr == `FSP_ADDR_FUSE_EXT)
		begin
			armed_byte = (extended_fuse_byte & `FSP_EXT_FUSE_MASK) | ~`FSP_EXT_FUSE_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lpm_special <= 1'b0;
			lpm_data <= `FSP_UNUSED_ONES;
		end
		else
		begin
			lpm_special <= lpm_go;
			if (lpm_go)
			begin
				lpm_data <= armed_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, data captured in the setup phase

	always_comb
	begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		if (paddr == `FSP_CTRL_OFFS)
		begin
			rd_word[7:0] = {irq_en, section_busy_flag, 1'b0, arm_cmd[4:1], spm_enable};
		end
		else if (paddr == `FSP_LOCK_OFFS)
		begin
			rd_word[7:0] = {`FSP_LOCK_PAD, boot_locks, general_locks};
		end
		else
		begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr <= !rd_hit;
		end
	end

	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// checks

	chk_window_expiry: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		ctrl_wr_ok ##1 (!spm_strobe && !lpm_strobe)[*4] |=> (arm_cmd == `FSP_CMD_NONE))
		else $error("store window did not expire after four cycles");

	chk_lock_read_clear: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		lpm_go |=> (arm_cmd == `FSP_CMD_NONE) && lpm_special)
		else $error("lock read did not clear the arm");

	chk_lock_read_value: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		lpm_go && (zptr == `FSP_ADDR_LOCK) |=> (lpm_data == {`FSP_LOCK_PAD, $past(boot_locks), general_locks}))
		else $error("lock byte read back wrong");

	chk_load_clears_busy: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		spm_go && (arm_cmd == `FSP_CMD_LOAD) |=> !section_busy_flag)
		else $error("page load left busy flag set");

	chk_no_rww_section_halt: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		eng_start && (arm_cmd == `FSP_CMD_WRITE) && !start_rww |=> core_halt && prog_active)
		else $error("no_rww_section page write did not halt the core");

	chk_lock_no_halt: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		eng_start && (arm_cmd == `FSP_CMD_LOCK) |=> prog_active && !core_halt)
		else $error("lock programming halted the core");

	chk_eeprom_blocks: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		eeprom_write_active && spm_strobe && !prog_active |=> !prog_active)
		else $error("flash command ran during eeprom write");

	chk_write_clears_buf: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		eng_done && (prog_op == fsp_op_write) |=> !pbuf.any_loaded)
		else $error("buffer not cleared after page write");

	chk_rww_busy: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		eng_start && start_rww |=> section_busy_flag && rww_read_block)
		else $error("rww section not marked busy");

	chk_page_held: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		prog_active && $past(prog_active) |-> $stable(prog_page))
		else $error("page address moved during programming");

	chk_irq_ready: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
		eng_done && irq_en && !ctrl_wr |=> spm_ready_irq)
		else $error("ready interrupt missing after programming");

endmodule : fsp_selfprog_ctrl

`default_nettype wire

//--- testbench/fsp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model
(
	input wire logic pclk,
	output logic spm_strobe,
	output logic lpm_strobe,
	output logic [15:0] zptr,
	output logic [15:0] data_word_pair
);
	initial
	begin
		spm_strobe = 1'b0;
		lpm_strobe = 1'b0;
		zptr = 16'h5555;
		data_word_pair = 16'haaaa;
	end
	////////////////////////////////////////////////////////////////////////////
	// caller sits just after a rising edge; operands stand for the strobe cycle
	task automatic spm(input logic [15:0] z, input logic [15:0] d);
		spm_strobe <= 1'b1;
		zptr <= z;
		data_word_pair <= d;
		@(posedge pclk);
		spm_strobe <= 1'b0;
		// released operands flip so a late sample is caught
		zptr <= ~z;
		data_word_pair <= ~d;
	endtask : spm
	task automatic lpm(input logic [15:0] z);
		lpm_strobe <= 1'b1;
		zptr <= z;
		@(posedge pclk);
		lpm_strobe <= 1'b0;
		zptr <= ~z;
	endtask : lpm
endmodule : fsp_core_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
module tb;
	import fsp_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, re;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rq;
	logic [3:0] pstrb = 4'hf;
	logic spm_strobe, lpm_strobe, lpm_special, spm_ready_irq, rww_read_block, core_halt, prog_active;
	logic [15:0] zptr, data_word_pair, prog_buf_data;
	logic eeprom_write_active = 1'b0;
	logic [7:0] fuse_low_byte = 8'h5c, fuse_high_byte = 8'h9a, extended_fuse_byte = 8'h0a, lpm_data;
	logic [1:0] general_locks = 2'h2;
	logic [6:0] prog_page;
	logic [3:0] boot_locks;
	logic [5:0] prog_buf_idx = 6'h00;
	fsp_op_t prog_op;
	int n_errors = 0, checks_done = 0;

	always #5 pclk = ~pclk;

	fsp_selfprog_ctrl #(.PROG_CYCLES(20)) dut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .spm_strobe, .lpm_strobe, .zptr, .data_word_pair,
		.eeprom_write_active, .fuse_low_byte, .fuse_high_byte, .extended_fuse_byte, .general_locks,
		.lpm_data, .lpm_special, .spm_ready_irq, .rww_read_block, .core_halt, .prog_active, .prog_op,
		.prog_page, .boot_locks, .prog_buf_idx, .prog_buf_data);
	fsp_core_model core (.pclk, .spm_strobe, .lpm_strobe, .zptr, .data_word_pair);

	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic timeout();
		n_errors++;
		$display("mismatch wait expected done seen hang");
		report_and_stop();
	endtask : timeout
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50)
			timeout();
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic ctrl(input logic [7:0] v);
		apb(1'b1, `FSP_CTRL_OFFS, {24'h0, v});
	endtask : ctrl
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("register read", exp, rq);
	endtask : rd_chk
	task automatic wait_idle();
		int i;
		for (i = 0; i < 200; i++)
		begin
			@(posedge pclk);
			#1;
			if (prog_active === 1'b0)
				break;
		end
		if (i == 200)
			timeout();
	endtask : wait_idle
	task automatic chk_buf(input logic [5:0] idx, input logic [15:0] exp);
		@(posedge pclk);
		prog_buf_idx <= idx;
		repeat (2) @(posedge pclk);
		#1;
		chk("buffer word", 32'(exp), 32'(prog_buf_data));
	endtask : chk_buf

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd_chk(`FSP_CTRL_OFFS, 32'h0);
		apb(1'b1, `FSP_LOCK_OFFS, 32'h0);
		rd_chk(`FSP_LOCK_OFFS, {24'h0, 2'h3, 4'hf, general_locks});
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped error", 32'h1, 32'(re));
		chk_buf(6'd5, 16'hffff);
	endtask : t_regs
	task automatic t_load();
		ctrl(8'h01);
		core.spm(16'h000a, 16'h1234);
		chk_buf(6'd5, 16'h1234);
		ctrl(8'h01);
		repeat (3) @(posedge pclk);
		core.spm(16'h000c, 16'h5678);
		chk_buf(6'd6, 16'h5678);
		ctrl(8'h01);
		repeat (4) @(posedge pclk);
		core.spm(16'h000e, 16'h9abc);
		chk_buf(6'd7, 16'hffff);
		ctrl(8'h07);
		core.spm(16'h0010, 16'h4321);
		chk_buf(6'd8, 16'hffff);
	endtask : t_load
	task automatic t_write();
		ctrl(8'h85);
		core.spm(16'h0180, 16'hdead);
		#1;
		chk("active", 32'h1, 32'(prog_active));
		chk("rww block", 32'h1, 32'(rww_read_block));
		chk("halt", 32'h0, 32'(core_halt));
		chk("page", 32'd3, 32'(prog_page));
		chk("op", 32'(fsp_op_write), 32'(prog_op));
		chk("irq", 32'h0, 32'(spm_ready_irq));
		rd_chk(`FSP_CTRL_OFFS, 32'hc1);
		wait_idle();
		chk("irq", 32'h1, 32'(spm_ready_irq));
		rd_chk(`FSP_CTRL_OFFS, 32'hc0);
		chk_buf(6'd5, 16'hffff);
		ctrl(8'h01);
		core.spm(16'h0012, 16'h0a0b);
		rd_chk(`FSP_CTRL_OFFS, 32'h00);
		ctrl(8'h11);
		core.spm(16'h0000, 16'h0000);
		chk_buf(6'd9, 16'hffff);
	endtask : t_write
	task automatic t_no_rww_section();
		ctrl(8'h05);
		core.spm(16'h3800, 16'h0000);
		#1;
		chk("halt", 32'h1, 32'(core_halt));
		chk("page", 32'd112, 32'(prog_page));
		wait_idle();
		chk("halt", 32'h0, 32'(core_halt));
		ctrl(8'h03);
		core.spm(16'h0100, 16'h0000);
		#1;
		chk("op", 32'(fsp_op_erase), 32'(prog_op));
		chk("rww block", 32'h1, 32'(rww_read_block));
		wait_idle();
		ctrl(8'h11);
		core.spm(16'h0000, 16'h0000);
	endtask : t_no_rww_section
	task automatic t_locks();
		logic [15:0] z[4];
		logic [7:0] e[4];
		z = '{16'h0000, 16'h0001, 16'h0002, 16'h0003};
		e = '{fuse_low_byte, {2'h3, 4'h6, general_locks}, (extended_fuse_byte & 8'h1e) | 8'he1, fuse_high_byte};
		ctrl(8'h09);
		core.spm(16'h0001, 16'h00db);
		#1;
		chk("halt", 32'h0, 32'(core_halt));
		chk("rww block", 32'h0, 32'(rww_read_block));
		wait_idle();
		chk("boot locks", 32'h6, 32'(boot_locks));
		rd_chk(`FSP_LOCK_OFFS, {24'h0, e[1]});
		for (int i = 0; i < 4; i++)
		begin
			ctrl(8'h09);
			core.lpm(z[i]);
			#1;
			chk("special", 32'h1, 32'(lpm_special));
			chk("lpm data", 32'(e[i]), 32'(lpm_data));
		end
		rd_chk(`FSP_CTRL_OFFS, 32'h00);
		ctrl(8'h09);
		repeat (3) @(posedge pclk);
		core.lpm(16'h0001);
		#1;
		chk("special", 32'h0, 32'(lpm_special));
		rd_chk(`FSP_CTRL_OFFS, 32'h00);
	endtask : t_locks
	task automatic t_eeprom();
		ctrl(8'h01);
		core.spm(16'h0014, 16'h1111);
		eeprom_write_active <= 1'b1;
		chk_buf(6'd10, 16'hffff);
		ctrl(8'h05);
		core.spm(16'h0200, 16'h0000);
		#1;
		chk("active", 32'h0, 32'(prog_active));
		ctrl(8'h09);
		core.lpm(16'h0000);
		#1;
		chk("special", 32'h0, 32'(lpm_special));
		@(posedge pclk);
		eeprom_write_active <= 1'b0;
	endtask : t_eeprom
	task automatic t_reset();
		ctrl(8'h01);
		core.spm(16'h0018, 16'h2222);
		ctrl(8'h05);
		core.spm(16'h0280, 16'h0000);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		chk("active", 32'h1, 32'(prog_active));
		wait_idle();
		chk("page", 32'd5, 32'(prog_page));
		ctrl(8'h01);
		core.spm(16'h001a, 16'h3333);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		chk_buf(6'd13, 16'hffff);
	endtask : t_reset

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		t_regs();
		t_load();
		t_write();
		t_no_rww_section();
		t_locks();
		t_eeprom();
		t_reset();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
